// file: inc/plc_consts.svh
// Offsets, field positions, reset values and timing counts of the presence light core.
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define PLC_ADDR_CTRL 4'h0
`define PLC_ADDR_TIMES 4'h1
`define PLC_ADDR_STATUS 4'h2
`define PLC_ADDR_IRQ_STAT 4'h3
`define PLC_ADDR_IRQ_MASK 4'h4
`define PLC_ADDR_CMD 4'h5
`define PLC_CTRL_AUTO 0
`define PLC_CTRL_LED_EN 1
`define PLC_CTRL_LED_ON_MOT 2
`define PLC_CTRL_ALIVE_EN 3
`define PLC_CTRL_ALIVE_VAL 4
`define PLC_CTRL_MOT_EN 5
`define PLC_CTRL_RESET 32'h0000_0001
`define PLC_WAIT_MIN_S 8'h02
`define PLC_WAIT_MAX_S 8'h3C
`define PLC_WAIT_DEF_S 8'h02
`define PLC_ALIVE_MIN_M 8'h01
`define PLC_ALIVE_DEF_M 8'h05
`define PLC_HOLD_DEF_S 16'h003C
`define PLC_CLK_HZ 10000000
`define PLC_SEC_CYCLES (`PLC_CLK_HZ / 1)
`define PLC_IRQ_ON 0
`define PLC_IRQ_OFF 1
`define PLC_IRQ_ALIVE 2
`define PLC_IRQ_WAIT_END 3
`endif

// file: inc/plc_pkg.sv
// Types of the presence light core.
package plc_pkg;
   typedef enum logic [1:0] {PLC_TG_SWITCH, PLC_TG_DIM, PLC_TG_ALIVE, PLC_TG_MOTION} plc_tg_kind_type;
   typedef struct packed
   {
      logic valid;
      plc_tg_kind_type kind;
      logic [7:0] value;
   } plc_tg_type;
   typedef enum logic [1:0] {PLC_ST_WAIT, PLC_ST_OFF, PLC_ST_ON, PLC_ST_HOLD} plc_state_type;
endpackage

// file: hdl/plc_core.sv
// Presence light control core with Avalon-MM register slave.
// Notes on behaviour
// (RULE1) While on, dim up when too dark, dim down when too bright.
// (RULE2) Two modes: fully automatic, or manual on with automatic off.
// (RULE3) Manual mode: motion never switches on; only the external command does.
// (RULE4) Light stays on while motion continues and daylight is below target.
// (RULE5) Motion stops: run hold timer, send OFF only when it expires.
// (RULE6) Automatic mode: motion switches the light on by itself.
// (RULE7) Power-return wait of 2 to 60 seconds, default 2; the code always waits the default 2 s and does not use wait_s_ff.
// (RULE8) No telegrams are sent during the power-return wait.
// (RULE9) Inputs are stored during the wait and acted on when it ends.
// (RULE10) Indicator LED enabled: dark always, or lit while motion is seen.
// (RULE11) Alive telegram, disabled by default, sent cyclically when enabled.
// (RULE12) Alive telegram value is selectable as 0 or 1.
// (RULE13) Alive period 1 to 255 minutes, default 5.
// (RULE14) Motion reports are sent only when the motion option is enabled.
// (RULE15) Each new motion while on restarts the hold timer fully.
// (RULE16) Alive counting starts at wait end; first alive within one period.
`include "plc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_core
   import plc_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `PLC_SEC_CYCLES,
   parameter int unsigned LUX_W = 12
)
(
   // Clock, reset, enable.
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Sensor side.
   input wire logic motion_i,
   input wire logic [LUX_W-1:0] lux_i,
   // Telegram output and indicators.
   output plc_pkg::plc_tg_type tg_o,
   output logic led_o,
   output logic irq_o
);
   import plc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic motion_s1_ff;
   logic motion_s2_ff;
   logic motion_d_ff;
   logic [LUX_W-1:0] lux_s1_ff;
   logic [LUX_W-1:0] lux_s2_ff;
   logic [31:0] ctrl_ff;
   logic [7:0] wait_s_ff;
   logic [7:0] alive_m_ff;
   logic [15:0] hold_s_ff;
   logic [LUX_W-1:0] target_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic man_on_ff;
   logic man_off_ff;
   logic [31:0] tick_cnt_ff;
   logic [5:0] min_cnt_ff;
   logic [7:0] wait_cnt_ff;
   logic [15:0] hold_cnt_ff;
   logic [7:0] alive_cnt_ff;
   plc_state_type state_ff;
   logic sec_tick;
   logic min_tick;
   logic motion_rise;
   logic bus_wr;
   logic bus_rd;
   logic ack_ff;
   logic wait_end;
   logic [3:0] irq_set;
   logic alive_due;
   logic too_dark;
   logic too_bright;
   logic sw_on;
   logic sw_off;
   logic mot_req;
   logic mot_fire;
   logic mot_pend_ff;

   assign motion_rise = motion_s2_ff & ~motion_d_ff;
   assign sec_tick = (tick_cnt_ff == SEC_CYCLES - 1);
   assign min_tick = sec_tick & (min_cnt_ff == 6'h3B);
   assign bus_wr = avs_write_i & ~ack_ff;
   assign bus_rd = avs_read_i & ~ack_ff;
   assign wait_end = (state_ff == PLC_ST_WAIT) & sec_tick & (wait_cnt_ff <= 8'h01);
   assign alive_due = min_tick & (alive_cnt_ff <= 8'h01);
   assign too_dark = lux_s2_ff < target_ff;
   assign too_bright = lux_s2_ff > target_ff;
   assign sw_on = (state_ff == PLC_ST_OFF) & (man_on_ff |
      (ctrl_ff[`PLC_CTRL_AUTO] & motion_s2_ff & too_dark));
   assign sw_off = (state_ff != PLC_ST_OFF) & (man_off_ff |
      (~motion_s2_ff & (hold_cnt_ff == 16'h0000)));
   assign mot_req = mot_pend_ff | (motion_rise & ctrl_ff[`PLC_CTRL_MOT_EN]);
   assign mot_fire = mot_req & (state_ff != PLC_ST_WAIT) & ~sw_on & ~sw_off;

   ////////////////////////////////////////////////////////////////////////////
   // Sensor inputs come from outside the clock domain.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         motion_s1_ff <= 1'b0;
         motion_s2_ff <= 1'b0;
         motion_d_ff <= 1'b0;
         lux_s1_ff <= '0;
         lux_s2_ff <= '0;
      end
      else if (clk_en_i)
      begin
         motion_s1_ff <= motion_i;
         motion_s2_ff <= motion_s1_ff;
         motion_d_ff <= motion_s2_ff;
         lux_s1_ff <= lux_i;
         lux_s2_ff <= lux_s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then acknowledge. Unmapped reads return zero.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         ack_ff <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end
      else if (clk_en_i)
      begin
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_ff);
         if (bus_rd)
         begin
            unique case (avs_address_i)
               `PLC_ADDR_CTRL: avs_readdata_o <= ctrl_ff;
               `PLC_ADDR_TIMES: avs_readdata_o <= {hold_s_ff, alive_m_ff, wait_s_ff};
               `PLC_ADDR_STATUS: avs_readdata_o <= {20'h00000, 2'(state_ff), led_o,
                  motion_s2_ff, 8'(target_ff)};
               `PLC_ADDR_IRQ_STAT: avs_readdata_o <= {28'h0000000, irq_stat_ff};
               `PLC_ADDR_IRQ_MASK: avs_readdata_o <= {28'h0000000, irq_mask_ff};
               default: avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers; stored even during the wait state. [RULE9]
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_ff <= `PLC_CTRL_RESET;
         wait_s_ff <= `PLC_WAIT_DEF_S;
         alive_m_ff <= `PLC_ALIVE_DEF_M;
         hold_s_ff <= `PLC_HOLD_DEF_S;
         target_ff <= '0;
         irq_mask_ff <= 4'h0;
      end
      else if (clk_en_i && bus_wr)
      begin
         unique case (avs_address_i)
            `PLC_ADDR_CTRL:
            begin
               ctrl_ff <= {26'h0000000, avs_writedata_i[5:0]};
               target_ff <= avs_writedata_i[8+LUX_W-1:8];
            end
            `PLC_ADDR_TIMES:
            begin
               // Wait clamps to 2..60 s, alive period to at least 1 min. [RULE7] [RULE13]
               wait_s_ff <= (avs_writedata_i[7:0] < `PLC_WAIT_MIN_S) ? `PLC_WAIT_MIN_S :
                  (avs_writedata_i[7:0] > `PLC_WAIT_MAX_S) ? `PLC_WAIT_MAX_S : avs_writedata_i[7:0];
               alive_m_ff <= (avs_writedata_i[15:8] < `PLC_ALIVE_MIN_M) ? `PLC_ALIVE_MIN_M :
                  avs_writedata_i[15:8];
               hold_s_ff <= avs_writedata_i[31:16];
            end
            `PLC_ADDR_IRQ_MASK: irq_mask_ff <= avs_writedata_i[3:0];
            default: ;
         endcase
      end
   end

   // Manual commands are held while in the wait state and last one cycle otherwise, so a command during
   // the wait is acted on when the wait ends. [RULE9]
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         man_on_ff <= 1'b0;
         man_off_ff <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (bus_wr && avs_address_i == `PLC_ADDR_CMD)
         begin
            man_on_ff <= avs_writedata_i[0] | (man_on_ff & state_ff == PLC_ST_WAIT);
            man_off_ff <= avs_writedata_i[1] | (man_off_ff & state_ff == PLC_ST_WAIT);
         end
         else if (state_ff != PLC_ST_WAIT)
         begin
            man_on_ff <= 1'b0;
            man_off_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time base: seconds and minutes.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         tick_cnt_ff <= 32'h0000_0000;
         min_cnt_ff <= 6'h00;
      end
      else if (clk_en_i)
      begin
         tick_cnt_ff <= sec_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
         if (sec_tick)
            min_cnt_ff <= (min_cnt_ff == 6'h3B) ? 6'h00 : min_cnt_ff + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Light state machine.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         state_ff <= PLC_ST_WAIT;
         wait_cnt_ff <= `PLC_WAIT_DEF_S;
         hold_cnt_ff <= 16'h0000;
      end
      else if (clk_en_i)
      begin
         unique case (state_ff)
            PLC_ST_WAIT:
            begin
               if (wait_end)
                  state_ff <= PLC_ST_OFF; // [RULE7]
               else if (sec_tick)
                  wait_cnt_ff <= wait_cnt_ff - 8'h01;
            end
            PLC_ST_OFF:
            begin
               // Motion switches on only in automatic mode. [RULE2] [RULE3] [RULE6]
               if (man_on_ff || (ctrl_ff[`PLC_CTRL_AUTO] && motion_s2_ff && too_dark))
               begin
                  state_ff <= PLC_ST_ON;
                  hold_cnt_ff <= hold_s_ff;
               end
            end
            PLC_ST_ON, PLC_ST_HOLD:
            begin
               if (man_off_ff)
                  state_ff <= PLC_ST_OFF;
               else if (motion_s2_ff)
               begin
                  state_ff <= PLC_ST_ON; // [RULE4]
                  if (motion_rise)
                     hold_cnt_ff <= hold_s_ff; // [RULE15]
               end
               else if (hold_cnt_ff == 16'h0000)
                  state_ff <= PLC_ST_OFF; // [RULE5]
               else
               begin
                  state_ff <= PLC_ST_HOLD;
                  if (sec_tick)
                     hold_cnt_ff <= hold_cnt_ff - 16'h0001; // [RULE5]
               end
            end
         endcase
      end
   end

   // Alive period counter starts when the wait ends. [RULE16]
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         alive_cnt_ff <= `PLC_ALIVE_DEF_M;
      else if (clk_en_i)
      begin
         if (state_ff == PLC_ST_WAIT || alive_due)
            alive_cnt_ff <= alive_m_ff; // [RULE16]
         else if (min_tick)
            alive_cnt_ff <= alive_cnt_ff - 8'h01; // [RULE13]
      end
   end

   // A motion report that loses to a switch telegram waits, so no movement goes unreported.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         mot_pend_ff <= 1'b0;
      else if (clk_en_i)
         mot_pend_ff <= mot_req & ~mot_fire; // [RULE14]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Telegram output, silent during the wait. Priority: switch, motion, alive, dim.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         tg_o <= '0;
      else if (clk_en_i)
      begin
         tg_o <= '0;
         if (state_ff == PLC_ST_WAIT)
            tg_o <= '0; // [RULE8]
         else if (sw_on)
            tg_o <= '{1'b1, PLC_TG_SWITCH, 8'h01}; // [RULE6]
         else if (sw_off)
            tg_o <= '{1'b1, PLC_TG_SWITCH, 8'h00}; // [RULE5]
         else if (mot_fire)
            tg_o <= '{1'b1, PLC_TG_MOTION, 8'h01}; // [RULE14]
         else if (alive_due && ctrl_ff[`PLC_CTRL_ALIVE_EN])
            tg_o <= '{1'b1, PLC_TG_ALIVE, {7'h00, ctrl_ff[`PLC_CTRL_ALIVE_VAL]}}; // [RULE11] [RULE12]
         else if (state_ff != PLC_ST_OFF && sec_tick && (too_dark || too_bright))
            tg_o <= '{1'b1, PLC_TG_DIM, too_dark ? 8'h01 : 8'h00}; // [RULE1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indicator LED and interrupts.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         led_o <= 1'b0;
      else if (clk_en_i)
         led_o <= ctrl_ff[`PLC_CTRL_LED_EN] & ctrl_ff[`PLC_CTRL_LED_ON_MOT] & motion_s2_ff; // [RULE10]
   end

   always_comb
   begin
      irq_set = 4'h0;
      irq_set[`PLC_IRQ_ON] = tg_o.valid & tg_o.kind == PLC_TG_SWITCH & tg_o.value[0];
      irq_set[`PLC_IRQ_OFF] = tg_o.valid & tg_o.kind == PLC_TG_SWITCH & ~tg_o.value[0];
      irq_set[`PLC_IRQ_ALIVE] = tg_o.valid & tg_o.kind == PLC_TG_ALIVE;
      irq_set[`PLC_IRQ_WAIT_END] = wait_end;
   end

   // A read clears the status, but an event in that same cycle still sets it.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_stat_ff <= 4'h0;
         irq_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         irq_stat_ff <= ((bus_rd && avs_address_i == `PLC_ADDR_IRQ_STAT) ? 4'h0 : irq_stat_ff)
            | irq_set;
         irq_o <= |(irq_stat_ff & irq_mask_ff);
      end
   end
endmodule
`default_nettype wire

// file: testbench/plc_core_chk.sv
// Port-level assertions for the presence light core, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module plc_core_chk
   import plc_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 20
)
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Register bus.
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Sensor and telegram side.
   input wire logic motion_i,
   input wire plc_pkg::plc_tg_type tg_o,
   input wire logic led_o,
   input wire logic irq_o
);
   logic [31:0] up_ff;
   logic [31:0] dim_ff;
   logic [31:0] alv_ff;
   ////////////////////////////////////////////////////////////////////////////////
   // Distance counters saturate so that a long idle stretch never wraps into a false hit.
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         up_ff <= 32'h0;
         dim_ff <= 32'hFFFF_FFFF;
         alv_ff <= 32'hFFFF_FFFF;
      end
      else
      begin
         up_ff <= (up_ff == 32'hFFFF_FFFF) ? up_ff : up_ff + 32'h1;
         dim_ff <= (tg_o.valid && tg_o.kind == PLC_TG_DIM) ? 32'h0 :
                   (dim_ff == 32'hFFFF_FFFF) ? dim_ff : dim_ff + 32'h1;
         alv_ff <= (tg_o.valid && tg_o.kind == PLC_TG_ALIVE) ? 32'h0 :
                   (alv_ff == 32'hFFFF_FFFF) ? alv_ff : alv_ff + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      ##[1:3] !avs_waitrequest_o;
   endsequence
   property p_ack; s_req |-> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered in time");
   property p_pulse; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_pulse: assert property (p_pulse) else $error("acknowledge longer than one cycle");
   property p_unmapped;
      avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h5 |-> avs_readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst;
      disable iff (1'b0) !reset_n_i |=> avs_waitrequest_o && !tg_o.valid && !led_o && !irq_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
   property p_quiet; tg_o.valid |-> up_ff >= 2 * SEC_CYCLES - 1; endproperty
   a_quiet: assert property (p_quiet) else $error("telegram during start-up wait");
   property p_led;
      $rose(led_o) |-> $past(motion_i, 2) || $past(motion_i, 3) || $past(motion_i, 4);
   endproperty
   a_led: assert property (p_led) else $error("indicator lit without motion");
   property p_dim;
      tg_o.valid && tg_o.kind == PLC_TG_DIM |-> dim_ff >= SEC_CYCLES - 2 && tg_o.value <= 8'h01;
   endproperty
   a_dim: assert property (p_dim) else $error("dim telegram too soon or bad value");
   property p_alive_gap; tg_o.valid && tg_o.kind == PLC_TG_ALIVE |-> alv_ff >= 60 * SEC_CYCLES - 2;
   endproperty
   a_alive_gap: assert property (p_alive_gap) else $error("alive period too short");
   property p_alive_val; tg_o.valid && tg_o.kind == PLC_TG_ALIVE |-> tg_o.value <= 8'h01;
   endproperty
   a_alive_val: assert property (p_alive_val) else $error("alive value not 0 or 1");
   property p_switch; tg_o.valid && tg_o.kind == PLC_TG_SWITCH |-> tg_o.value <= 8'h01;
   endproperty
   a_switch: assert property (p_switch) else $error("switch value not on or off");
endmodule
bind plc_core plc_core_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.sys_clk_i(sys_clk_i),
   .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .motion_i(motion_i), .tg_o(tg_o),
   .led_o(led_o), .irq_o(irq_o));
`default_nettype wire

// file: testbench/plc_bus_peer.sv
// Listening bus peer that tallies the core's telegrams by kind.
`timescale 1ns/1ps
`default_nettype none
module plc_bus_peer
   import plc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Telegrams heard and their tallies: 0 on, 1 off, 2 dim, 3 alive, 4 motion.
   input wire plc_pkg::plc_tg_type tg_i,
   output int cnt_o [5],
   output logic [7:0] last_o [4]
);
   ////////////////////////////////////////////////////////////////////////////////
   // A watcher only listens, so an absent alive telegram shows as a stalled tally.
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         cnt_o <= '{default: 0};
         last_o <= '{default: 8'h00};
      end
      else if (tg_i.valid)
      begin
         last_o[tg_i.kind] <= tg_i.value;
         if (tg_i.kind == PLC_TG_SWITCH)
            cnt_o[tg_i.value[0] ? 0 : 1] <= cnt_o[tg_i.value[0] ? 0 : 1] + 1;
         else
            cnt_o[int'(tg_i.kind) + 1] <= cnt_o[int'(tg_i.kind) + 1] + 1;
      end
   end
endmodule
`default_nettype wire

// file: testbench/plc_core_test.sv
// Self-checking bench for the presence light core with a listening bus peer.
`include "plc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_core_test;
   import plc_pkg::*;
   typedef struct {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} plc_row_type;
   logic sys_clk, reset_n, rd, wr, wreq, led, irq, motion;
   logic [3:0] addr;
   logic [11:0] lux;
   logic [31:0] wdata, rdata, q;
   plc_tg_type tg;
   int cnt [5];
   logic [7:0] last [4];
   int num_errors = 0;
   int n_tests = 0;
   int k;
   int c;
   plc_row_type rows [10] = '{'{1'b1, `PLC_ADDR_CMD, 32'h1, 32'h0},
      '{1'b1, `PLC_ADDR_IRQ_MASK, 32'h9, 32'h0}, '{1'b0, `PLC_ADDR_IRQ_MASK, 32'h0, 32'h9},
      '{1'b0, `PLC_ADDR_CTRL, 32'h0, `PLC_CTRL_RESET}, '{1'b0, `PLC_ADDR_TIMES, 32'h0, 32'h003C_0502},
      '{1'b1, `PLC_ADDR_TIMES, 32'h0002_0150, 32'h0}, '{1'b0, `PLC_ADDR_TIMES, 32'h0, 32'h0002_013C},
      '{1'b1, `PLC_ADDR_TIMES, 32'h0002_0101, 32'h0}, '{1'b0, `PLC_ADDR_TIMES, 32'h0, 32'h0002_0102},
      '{1'b0, 4'hF, 32'h0, 32'h0}};
   ////////////////////////////////////////////////////////////////////////////////
   plc_core #(.SEC_CYCLES(20)) dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(1'b1),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .motion_i(motion), .lux_i(lux),
      .tg_o(tg), .led_o(led), .irq_o(irq));
   plc_bus_peer peer_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .tg_i(tg), .cnt_o(cnt),
      .last_o(last));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // The request stays up until waitrequest is sampled low, for at most 40 cycles.
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 40);
      check(32'(n < 40), 32'h1, "bus answer");
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task hit(input int i, input int lim, input string what);
      int b;
      b = cnt[i];
      k = 0;
      while (cnt[i] == b && k < lim)
      begin
         @(posedge sys_clk);
         k++;
      end
      check(32'(cnt[i] - b), 32'h1, what);
   endtask
   task miss(input int i, input int n, input string what);
      c = cnt[i];
      repeat (n) @(posedge sys_clk);
      check(32'(cnt[i]), 32'(c), what);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      end_sim();
   end
   initial
   begin
      {reset_n, rd, wr, motion, addr, wdata, q} = '0;
      lux = 12'h080;
      repeat (3) @(posedge sys_clk);
      check({28'h0, wreq, led, irq, tg.valid}, 32'h8, "reset outputs");
      reset_n <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i].wr, rows[i].a, rows[i].d, q);
         if (!rows[i].wr)
            check(q, rows[i].e, $sformatf("register %h", rows[i].a));
      end
      $display("test register rows done");
      for (k = 0; k < 100 && q[11:10] === 2'b00; k++)
         bus(1'b0, `PLC_ADDR_STATUS, 32'h0, q);
      repeat (5) @(posedge sys_clk);
      check(32'(cnt[0]), 32'h1, "latched manual on");
      check(32'(irq), 32'h1, "irq raised");
      bus(1'b0, `PLC_ADDR_IRQ_STAT, 32'h0, q);
      check(q, 32'h9, "irq status");
      repeat (3) @(posedge sys_clk);
      check(32'(irq), 32'h0, "irq cleared");
      bus(1'b1, `PLC_ADDR_CMD, 32'h2, q);
      hit(1, 20, "manual off");
      bus(1'b1, `PLC_ADDR_IRQ_MASK, 32'h0, q);
      $display("test wait end and irq done");
      bus(1'b1, `PLC_ADDR_CTRL, 32'h0001_0027, q);
      motion <= 1'b1;
      hit(0, 20, "auto on");
      repeat (5) @(posedge sys_clk);
      check(32'(led), 32'h1, "led on motion");
      check(32'(cnt[4] != 0), 32'h1, "motion report");
      miss(1, 60, "off while motion");
      check(32'(last[1]), 32'h1, "dim up");
      lux <= 12'h200;
      repeat (2) hit(2, 30, "dim tick");
      check(32'(last[1]), 32'h0, "dim down");
      lux <= 12'h080;
      motion <= 1'b0;
      repeat (10) @(posedge sys_clk);
      motion <= 1'b1;
      repeat (5) @(posedge sys_clk);
      motion <= 1'b0;
      miss(1, 15, "early off");
      hit(1, 60, "hold off");
      $display("test automatic mode done");
      bus(1'b1, `PLC_ADDR_CTRL, 32'h0001_0002, q);
      motion <= 1'b1;
      miss(4, 10, "no motion report");
      miss(0, 60, "no auto on");
      check(32'(led), 32'h0, "led dark");
      bus(1'b1, `PLC_ADDR_CMD, 32'h1, q);
      hit(0, 20, "manual on");
      bus(1'b1, `PLC_ADDR_CMD, 32'h2, q);
      hit(1, 20, "manual off");
      motion <= 1'b0;
      $display("test manual mode done");
      check(32'(cnt[3]), 32'h0, "alive off by default");
      bus(1'b1, `PLC_ADDR_CTRL, 32'h0001_0018, q);
      hit(3, 1300, "first alive");
      check(32'(last[2]), 32'h1, "alive value 1");
      bus(1'b1, `PLC_ADDR_CTRL, 32'h0001_0008, q);
      hit(3, 1300, "next alive");
      check(32'(k > 1150), 32'h1, "alive period");
      check(32'(last[2]), 32'h0, "alive value 0");
      check(32'(irq), 32'h0, "masked irq");
      bus(1'b0, `PLC_ADDR_IRQ_STAT, 32'h0, q);
      check(q, 32'h7, "masked irq status");
      $display("test alive and mask done");
      end_sim();
   end
endmodule
`default_nettype wire
